/* rtl/dma_err_regs.svh */
/*
 * Register offsets, field positions, reset values and widths of the
 * transfer controller error block.
 * Assumes byte addressing on a 32-bit APB, one aligned word a register.
 */
`ifndef DMA_ERR_REGS_SVH
`define DMA_ERR_REGS_SVH

`define ERR_ADDR_W 12
`define ERR_STATUS_OFS 12'h000
`define ERR_ENABLE_OFS 12'h004
`define ERR_CLEAR_OFS 12'h008
`define ERR_DETAILS_OFS 12'h00C

`define ERR_BUS_BIT 0
`define ERR_RSV_BIT 1
`define ERR_REQ_BIT 2
`define ERR_ADDR_BIT 3

`define DET_STAT_LSB 0
`define DET_CODE_LSB 8
`define DET_INTEN_BIT 16
`define DET_CHAIN_BIT 17

`define STAT_W 4
`define CODE_W 6
`define CNT_W 16
`define ENABLE_RST 4'h0
`define STAT_NONE 4'h0
`define ALIGN_BITS_DEF 5

`endif

/* rtl/dma_err_pkg.sv */
/*
 * Types for the transfer controller error block.
 * Assumes dma_err_regs.svh is compiled alongside.
 */
`include "dma_err_regs.svh"

package dma_err_pkg;

	// whole state of the error block, registered as one word
	typedef struct packed {
		logic addrFault;
		logic reqFault;
		logic busFault;
		logic [3:0] enable;
		logic [`STAT_W-1:0] detStat;
		logic [`CODE_W-1:0] detCode;
		logic detIntEn;
		logic detChainEn;
		logic [31:0] rdata;
	} err_state_t;

endpackage

/* rtl/bus_status_pick.sv */
/*
 * Picks one bus status report when read and write status may arrive
 * together, with the transfer options that travel with it.
 * Assumes both status buses are on the block's clock.
 */
`timescale 1ns/1ps
`include "dma_err_regs.svh"

module bus_status_pick
	import dma_err_pkg::*;
(
	// read status bus
	input wire logic [`STAT_W-1:0] rdStat,
	input wire logic [`CODE_W-1:0] rdCode,
	input wire logic rdIntEn,
	input wire logic rdChainEn,
	// write status bus
	input wire logic [`STAT_W-1:0] wrStat,
	input wire logic [`CODE_W-1:0] wrCode,
	input wire logic wrIntEn,
	input wire logic wrChainEn,
	// chosen report
	output logic hit,
	output logic [`STAT_W-1:0] selStat,
	output logic [`CODE_W-1:0] selCode,
	output logic selIntEn,
	output logic selChainEn
);

	logic useWr;

	// a nonzero write status outranks a nonzero read status
	assign useWr = (wrStat != `STAT_NONE); // RULE9
	assign hit = useWr || (rdStat != `STAT_NONE);
	assign selStat = useWr ? wrStat : rdStat; // RULE9
	assign selCode = useWr ? wrCode : rdCode; // RULE10
	assign selIntEn = useWr ? wrIntEn : rdIntEn; // RULE10
	assign selChainEn = useWr ? wrChainEn : rdChainEn; // RULE10

endmodule

/* rtl/dma_tc_error_reporting.sv */
/*
 * Error reporting register bank of a DMA transfer controller: three
 * sticky fault flags, interrupt enables, write-one clear and a capture
 * of the bus fault particulars, reached over APB.
 * Assumes request and bus status inputs come from logic on clock.
 */
// The register offsets and the APB interface to the registers were decided locally.
// Functional notes
// RULE1: access to an unmapped address in register space sets status bit 3.
// RULE2: bad constant-mode alignment or zero first/second count sets bit 2.
// RULE3: source/destination bus error sets bit 0; particulars go to details.
// RULE4: interrupt is high while any status bit and its enable are set.
// RULE5: enable bits 3, 2, 0 are read/write, reset 0, 0 masks the flag.
// RULE6: software writes 0 to reserved enable bit 1.
// RULE7: clear bits 3 and 2 clear their flag only; writing 0 does nothing.
// RULE8: clear bit 0 clears the bus flag and wipes the details register.
// RULE9: details keep the nonzero 4-bit status; write status wins a tie.
// RULE10: details also hold code, interrupt and chaining enables of it.
// RULE11: flags stay set until cleared, so the interrupt is a level.
`timescale 1ns/1ps
`include "dma_err_regs.svh"

module dma_tc_error_reporting
	import dma_err_pkg::*;
#(
	parameter int ALIGN_BITS = `ALIGN_BITS_DEF
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ERR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// incoming transfer request
	input wire logic reqValid,
	input wire logic reqSrcConst,
	input wire logic reqDstConst,
	input wire logic [31:0] reqSrcAddr,
	input wire logic [31:0] reqDstAddr,
	input wire logic [`CNT_W-1:0] reqFirstCount,
	input wire logic [`CNT_W-1:0] reqSecondCount,
	// read status bus
	input wire logic [`STAT_W-1:0] rdStat,
	input wire logic [`CODE_W-1:0] rdCode,
	input wire logic rdIntEn,
	input wire logic rdChainEn,
	// write status bus
	input wire logic [`STAT_W-1:0] wrStat,
	input wire logic [`CODE_W-1:0] wrCode,
	input wire logic wrIntEn,
	input wire logic wrChainEn,
	// interrupt
	output logic errorIrq
);

	// the alignment mask must fit a 32-bit address
	if (ALIGN_BITS < 1 || ALIGN_BITS > 12)
	begin : g_check
		$error("ALIGN_BITS out of range");
	end

	err_state_t st;
	err_state_t next_st;
	logic setup;
	logic access;
	logic mapped;
	logic wrAcc;
	logic addrEvt;
	logic reqEvt;
	logic busHit;
	logic [`STAT_W-1:0] selStat;
	logic [`CODE_W-1:0] selCode;
	logic selIntEn;
	logic selChainEn;
	logic [31:0] alignMask;
	logic srcBad;
	logic dstBad;
	logic [31:0] statusWord;
	logic [31:0] enableWord;
	logic [31:0] detailsWord;

	// status bus arbitration lives in its own leaf
	bus_status_pick i_bus_status_pick (
		.rdStat(rdStat),
		.rdCode(rdCode),
		.rdIntEn(rdIntEn),
		.rdChainEn(rdChainEn),
		.wrStat(wrStat),
		.wrCode(wrCode),
		.wrIntEn(wrIntEn),
		.wrChainEn(wrChainEn),
		.hit(busHit),
		.selStat(selStat),
		.selCode(selCode),
		.selIntEn(selIntEn),
		.selChainEn(selChainEn)
	);

	// bus phases and address decode
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign mapped = (paddr == `ERR_STATUS_OFS) ||
		(paddr == `ERR_ENABLE_OFS) ||
		(paddr == `ERR_CLEAR_OFS) ||
		(paddr == `ERR_DETAILS_OFS);
	assign wrAcc = access && pwrite && mapped;
	// zero wait states: read data was staged during setup
	assign pready = access;
	assign pslverr = access && !mapped;
	assign prdata = st.rdata;

	// an access outside the map is a fault, read or write alike
	assign addrEvt = access && !mapped; // RULE1

	// constant addressing needs aligned addresses; counts must be nonzero
	assign alignMask = (32'h1 << ALIGN_BITS) - 32'h1;
	assign srcBad = reqSrcConst && ((reqSrcAddr & alignMask) != 32'h0);
	assign dstBad = reqDstConst && ((reqDstAddr & alignMask) != 32'h0);
	assign reqEvt = reqValid && (srcBad || dstBad || // RULE2
		reqFirstCount == '0 || reqSecondCount == '0); // RULE2

	// read views; reserved bits read as zero, except enable bit 1, which reads back as written
	always_comb
	begin
		statusWord = 32'h0;
		statusWord[`ERR_ADDR_BIT] = st.addrFault;
		statusWord[`ERR_REQ_BIT] = st.reqFault;
		statusWord[`ERR_BUS_BIT] = st.busFault;
		enableWord = 32'h0;
		enableWord[3:0] = st.enable;
		detailsWord = 32'h0;
		detailsWord[`DET_STAT_LSB +: `STAT_W] = st.detStat;
		detailsWord[`DET_CODE_LSB +: `CODE_W] = st.detCode;
		detailsWord[`DET_INTEN_BIT] = st.detIntEn;
		detailsWord[`DET_CHAIN_BIT] = st.detChainEn;
	end

	// next state: clears first, then events, so a set in the
	// same cycle as its clear survives
	always_comb
	begin
		next_st = st;
		if (wrAcc && paddr == `ERR_ENABLE_OFS)
		begin
			// bit 1 is stored but never gates anything
			next_st.enable = pwdata[3:0]; // RULE5
		end
		if (wrAcc && paddr == `ERR_CLEAR_OFS)
		begin
			if (pwdata[`ERR_ADDR_BIT])
			begin
				next_st.addrFault = 1'b0; // RULE7
			end
			if (pwdata[`ERR_REQ_BIT])
			begin
				next_st.reqFault = 1'b0; // RULE7
			end
			if (pwdata[`ERR_BUS_BIT])
			begin
				next_st.busFault = 1'b0; // RULE8
				next_st.detStat = `STAT_NONE; // RULE8
				next_st.detCode = '0; // RULE8
				next_st.detIntEn = 1'b0; // RULE8
				next_st.detChainEn = 1'b0; // RULE8
			end
		end
		// flags are sticky: only the clear path above lowers them
		if (addrEvt)
		begin
			next_st.addrFault = 1'b1; // RULE1 RULE11
		end
		if (reqEvt)
		begin
			next_st.reqFault = 1'b1; // RULE2 RULE11
		end
		if (busHit)
		begin
			next_st.busFault = 1'b1; // RULE3 RULE11
			// keep the first fault's particulars until software clears
			if (!st.busFault || next_st.detStat == `STAT_NONE)
			begin
				next_st.detStat = selStat; // RULE3 RULE9
				next_st.detCode = selCode; // RULE10
				next_st.detIntEn = selIntEn; // RULE10
				next_st.detChainEn = selChainEn; // RULE10
			end
		end
		// stage read data in setup so it comes from a flop in access
		if (setup)
		begin
			case (paddr)
				`ERR_STATUS_OFS: next_st.rdata = statusWord;
				`ERR_ENABLE_OFS: next_st.rdata = enableWord;
				`ERR_DETAILS_OFS: next_st.rdata = detailsWord;
				default: next_st.rdata = 32'h0;
			endcase
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st <= '0;
			st.enable <= `ENABLE_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	// reserved enable bit 1 is deliberately left out of the gate
	assign errorIrq = (st.addrFault && st.enable[`ERR_ADDR_BIT]) || // RULE4
		(st.reqFault && st.enable[`ERR_REQ_BIT]) || // RULE5
		(st.busFault && st.enable[`ERR_BUS_BIT]); // RULE4

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	unmapped_sets_flag_a: assert property ( // RULE1
		addrEvt |=> st.addrFault)
		else $error("unmapped access did not set the address flag");

	bad_request_flag_a: assert property ( // RULE2
		reqValid && reqFirstCount == '0 |=> st.reqFault)
		else $error("zero count request did not set the request flag");

	bus_error_capture_a: assert property ( // RULE3
		busHit && !st.busFault |=> st.busFault && st.detStat != `STAT_NONE)
		else $error("bus error not captured");

	irq_follows_flags_a: assert property ( // RULE4
		errorIrq == ((st.addrFault && st.enable[`ERR_ADDR_BIT]) ||
		(st.reqFault && st.enable[`ERR_REQ_BIT]) ||
		(st.busFault && st.enable[`ERR_BUS_BIT])))
		else $error("interrupt does not match flags and enables");

	// reserved enable bit 1 alone must never raise the interrupt
	masked_flag_quiet_a: assert property ( // RULE5
		!st.enable[`ERR_ADDR_BIT] && !st.enable[`ERR_REQ_BIT] &&
		!st.enable[`ERR_BUS_BIT] |-> !errorIrq)
		else $error("interrupt raised with all enables off");

	// a same-cycle request fault would win over the clear, so skip it
	clear_keeps_details_a: assert property ( // RULE7
		wrAcc && paddr == `ERR_CLEAR_OFS && pwdata[`ERR_ADDR_BIT] &&
		pwdata[`ERR_REQ_BIT] && !pwdata[`ERR_BUS_BIT] && !busHit && !reqEvt
		|=> !st.reqFault && !st.addrFault && $stable(st.detStat))
		else $error("request or address clear misbehaved");

	bus_clear_wipes_a: assert property ( // RULE8
		wrAcc && paddr == `ERR_CLEAR_OFS && pwdata[0] && !busHit
		|=> !st.busFault && st.detStat == `STAT_NONE && st.detCode == '0)
		else $error("bus clear left flag or details");

	write_status_wins_a: assert property ( // RULE9
		!st.busFault && wrStat != `STAT_NONE && rdStat != `STAT_NONE
		|=> st.detStat == $past(wrStat) && st.detCode == $past(wrCode))
		else $error("write status did not win the tie");

	flag_sticky_a: assert property ( // RULE11
		st.reqFault && !(wrAcc && paddr == `ERR_CLEAR_OFS &&
		pwdata[`ERR_REQ_BIT]) |=> st.reqFault)
		else $error("request flag dropped without a clear");

	bus_flag_sticky_a: assert property ( // RULE11
		st.busFault && !(wrAcc && paddr == `ERR_CLEAR_OFS &&
		pwdata[`ERR_BUS_BIT]) |=> st.busFault)
		else $error("bus flag dropped without a clear");

	addr_flag_sticky_a: assert property ( // RULE11
		st.addrFault && !(wrAcc && paddr == `ERR_CLEAR_OFS &&
		pwdata[`ERR_ADDR_BIT]) |=> st.addrFault)
		else $error("address flag dropped without a clear");

	// the low address bit lies inside every legal alignment mask
	src_misalign_flag_a: assert property ( // RULE2
		reqValid && reqSrcConst && reqSrcAddr[0] |=> st.reqFault)
		else $error("misaligned constant source did not set the flag");

	dst_misalign_flag_a: assert property ( // RULE2
		reqValid && reqDstConst && reqDstAddr[0] |=> st.reqFault)
		else $error("misaligned constant destination left flag clear");

	// later faults must not overwrite the particulars of the first
	first_fault_kept_a: assert property ( // RULE3
		st.busFault && !(wrAcc && paddr == `ERR_CLEAR_OFS &&
		pwdata[`ERR_BUS_BIT]) |=> $stable(st.detStat))
		else $error("details changed while the bus flag was set");

	unmapped_reads_zero_a: assert property ( // RULE1
		access && !mapped && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read returned nonzero data");

	read_status_alone_a: assert property ( // RULE9
		!st.busFault && wrStat == `STAT_NONE && rdStat != `STAT_NONE
		|=> st.detStat == $past(rdStat) && st.detCode == $past(rdCode))
		else $error("read status alone was not captured");

endmodule

/* tb/dma_tc_error_reporting_test.sv */
/*
 * Self-checking bench for the error reporting register bank.
 * Assumes a zero wait state APB slave and offsets from dma_err_regs.svh.
 */
`timescale 1ns/1ps
`include "dma_err_regs.svh"

module dma_tc_error_reporting_test;
	import dma_err_pkg::*;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, errorIrq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic reqValid, reqSrcConst, reqDstConst, rdIntEn, rdChainEn;
	logic wrIntEn, wrChainEn, er;
	logic [31:0] reqSrcAddr, reqDstAddr;
	logic [15:0] reqFirstCount, reqSecondCount;
	logic [3:0] rdStat, wrStat;
	logic [5:0] rdCode, wrCode;
	int fails, total_checks;

	dma_tc_error_reporting i_dma_tc_error_reporting (.clock(clock),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reqValid(reqValid), .reqSrcConst(reqSrcConst),
		.reqDstConst(reqDstConst), .reqSrcAddr(reqSrcAddr),
		.reqDstAddr(reqDstAddr), .reqFirstCount(reqFirstCount),
		.reqSecondCount(reqSecondCount), .rdStat(rdStat), .rdCode(rdCode),
		.rdIntEn(rdIntEn), .rdChainEn(rdChainEn), .wrStat(wrStat),
		.wrCode(wrCode), .wrIntEn(wrIntEn), .wrChainEn(wrChainEn),
		.errorIrq(errorIrq));

	// free running 50 MHz clock
	initial
	begin
		clock = 0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, entered and left just after a rising edge; an
	// idle cycle follows so psel is never assigned twice in one step
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		// no wait count is assumed: the watchdog ends a hung access
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask

	// read a register and compare it
	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h0);
		chk(rd, exp);
	endtask

	// interrupt is judged mid-cycle, where flags have settled
	task automatic irqChk(input logic exp);
		@(negedge clock);
		chk({31'h0, errorIrq}, {31'h0, exp});
		@(posedge clock);
	endtask

	// one-cycle request pulse; flag is visible after the next edge
	task automatic req(input logic sc, input logic [31:0] sa,
		input logic dc, input logic [31:0] da,
		input logic [15:0] c1, input logic [15:0] c2);
		reqValid <= 1;
		reqSrcConst <= sc;
		reqSrcAddr <= sa;
		reqDstConst <= dc;
		reqDstAddr <= da;
		reqFirstCount <= c1;
		reqSecondCount <= c2;
		@(posedge clock);
		reqValid <= 0;
		@(posedge clock);
	endtask

	// one cycle of read and write status together
	task automatic bus(input logic [3:0] r, input logic [3:0] w);
		rdStat <= r;
		wrStat <= w;
		@(posedge clock);
		rdStat <= 4'h0;
		wrStat <= 4'h0;
		@(posedge clock);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog at 2000 cycles, far beyond the fewer than 200 cycles the run needs
	initial
	begin
		#40000;
		fails++;
		give_verdict;
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{reqValid, reqSrcConst, reqDstConst, reqSrcAddr, reqDstAddr} = '0;
		{reqFirstCount, reqSecondCount, rdStat, wrStat} = '0;
		rdCode = 6'h15;
		rdIntEn = 0;
		rdChainEn = 1;
		wrCode = 6'h2A;
		wrIntEn = 1;
		wrChainEn = 0;
		rst = 1;
		fails = 0;
		total_checks = 0;
		repeat (2) @(posedge clock);
		rst <= 0;
		reset_values;
		unmapped_access;
		enable_mask;
		request_faults;
		bus_fault_capture;
		midrun_reset;
		give_verdict;
	end

	// everything reads zero and the interrupt is low after reset
	task automatic reset_values;
		rdChk(`ERR_STATUS_OFS, 32'h0);
		chk({31'h0, er}, 32'h0);
		rdChk(`ERR_ENABLE_OFS, 32'h0);
		rdChk(`ERR_DETAILS_OFS, 32'h0);
		rdChk(`ERR_CLEAR_OFS, 32'h0);
		irqChk(0);
	endtask

	// unmapped reads and writes both raise the address flag
	task automatic unmapped_access;
		xfer(1, `ERR_ENABLE_OFS, 32'h0000000D);
		rdChk(`ERR_ENABLE_OFS, 32'h0000000D);
		irqChk(0);
		rdChk(12'h010, 32'h0);
		chk({31'h0, er}, 32'h1);
		rdChk(`ERR_STATUS_OFS, 32'h8);
		irqChk(1);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000008);
		rdChk(`ERR_STATUS_OFS, 32'h0);
		irqChk(0);
		xfer(1, 12'hFFC, 32'h0000000F);
		chk({31'h0, er}, 32'h1);
		rdChk(`ERR_STATUS_OFS, 32'h8);
		rdChk(`ERR_ENABLE_OFS, 32'h0000000D);
		xfer(1, `ERR_STATUS_OFS, 32'h00000000);
		rdChk(`ERR_STATUS_OFS, 32'h8);
	endtask

	// only enable bit 3 unmasks the address flag
	task automatic enable_mask;
		xfer(1, `ERR_ENABLE_OFS, 32'h00000005);
		irqChk(0);
		rdChk(`ERR_ENABLE_OFS, 32'h00000005);
		xfer(1, `ERR_ENABLE_OFS, 32'h00000009);
		irqChk(1);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000008);
		rdChk(`ERR_STATUS_OFS, 32'h0);
		irqChk(0);
		xfer(1, `ERR_ENABLE_OFS, 32'h00000005);
	endtask

	// aligned constant modes pass; bad alignment or zero counts fault
	task automatic request_faults;
		req(1, 32'h20, 1, 32'h40, 16'h10, 16'h1);
		rdChk(`ERR_STATUS_OFS, 32'h0);
		req(0, 32'h0, 0, 32'h0, 16'h10, 16'h0);
		rdChk(`ERR_STATUS_OFS, 32'h4);
		irqChk(1);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000004);
		rdChk(`ERR_STATUS_OFS, 32'h0);
		irqChk(0);
		req(0, 32'h0, 1, 32'h4, 16'h10, 16'h1);
		rdChk(`ERR_STATUS_OFS, 32'h4);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000004);
		rdChk(`ERR_STATUS_OFS, 32'h0);
		req(1, 32'h10, 0, 32'h0, 16'h10, 16'h1);
		rdChk(`ERR_STATUS_OFS, 32'h4);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000004);
		req(0, 32'h0, 0, 32'h0, 16'h0, 16'h1);
		rdChk(`ERR_STATUS_OFS, 32'h4);
	endtask

	// capture, priority, first fault kept, and the two clear flavours
	task automatic bus_fault_capture;
		bus(4'h1, 4'h9);
		rdChk(`ERR_STATUS_OFS, 32'h5);
		rdChk(`ERR_DETAILS_OFS, 32'h00012A09);
		bus(4'h2, 4'h0);
		rdChk(`ERR_DETAILS_OFS, 32'h00012A09);
		xfer(1, `ERR_CLEAR_OFS, 32'h0000000C);
		rdChk(`ERR_DETAILS_OFS, 32'h00012A09);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000000);
		rdChk(`ERR_STATUS_OFS, 32'h1);
		irqChk(1);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000001);
		rdChk(`ERR_STATUS_OFS, 32'h0);
		rdChk(`ERR_DETAILS_OFS, 32'h0);
		irqChk(0);
		bus(4'h3, 4'h0);
		rdChk(`ERR_DETAILS_OFS, 32'h00021503);
		xfer(1, `ERR_CLEAR_OFS, 32'h00000001);
		bus(4'h0, 4'hC);
		rdChk(`ERR_DETAILS_OFS, 32'h00012A0C);
	endtask

	// a reset in mid-run wipes flags, enables and details
	task automatic midrun_reset;
		irqChk(1);
		rst <= 1;
		repeat (2) @(posedge clock);
		rst <= 0;
		reset_values;
	endtask
endmodule
